// ===== common/pcm_pkg.sv
// Constants and carrier types for the port C and D pin mode block.
`default_nettype none
package pcm_pkg;
	localparam int          PCM_PINS         = 8;
	localparam int          PCM_PORTS        = 2;
	localparam int          PCM_MODE_W       = 2;
	localparam int          PCM_PORT_C       = 0;
	localparam int          PCM_PORT_D       = 1;
	localparam int          PCM_DEDICATED    = 5;
	localparam logic [7:0]  PCM_OFS_C_MODE   = 8'h00;
	localparam logic [7:0]  PCM_OFS_D_MODE   = 8'h04;
	localparam logic [7:0]  PCM_OFS_LEVEL    = 8'h08;
	localparam logic [15:0] PCM_C_MODE_RESET = 16'hF000;
	localparam logic [15:0] PCM_D_MODE_RESET = 16'hF0CC;
	localparam logic [1:0]  PCM_MODE_ALT     = 2'h0;
	localparam logic [1:0]  PCM_MODE_OUT     = 2'h1;
	localparam logic [1:0]  PCM_MODE_IN_PU   = 2'h2;
	localparam logic [1:0]  PCM_MODE_IN      = 2'h3;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} pcm_wb_req_type;

	typedef struct packed {
		logic drive_gpio;
		logic pass_alt;
		logic pull_up;
	} pcm_pin_ctl_type;
endpackage : pcm_pkg
`default_nettype wire

// ===== hw/pcm_pin_mode.sv
// Pin mode control for ports C and D with a classic Wishbone slave.
//
// What this block does
// - Both 16-bit mode registers fully readable and writable.
// - Mode 00 gives alternate function; 01 drives output.
// - Mode 10 is input with pull-up on.
// - Mode 11 is input with pull-up off.
// - Port D pin 5: 00 dedicated, 01 never drives.
// - Port C resets pins 7,6 to 11, rest 00.
// - Port D resets pins 7,6,3,1 to 11.
//
// Our own choices: the Wishbone register port and the register offsets.
`default_nettype none
module pcm_pin_mode
	import pcm_pkg::*;
(
	input  wire logic                               clk_i,
	input  wire logic                               rst_i,
	input  wire pcm_wb_req_type                     wb_req_i,
	output logic                                    wb_ack_o,
	output logic [31:0]                             wb_dat_o,
	input  wire logic [PCM_PORTS-1:0][PCM_PINS-1:0] pad_in_i,
	output logic [PCM_PORTS-1:0][PCM_PINS-1:0]      pad_out_o,
	output logic [PCM_PORTS-1:0][PCM_PINS-1:0]      pad_oe_o,
	output logic [PCM_PORTS-1:0][PCM_PINS-1:0]      pull_up_o,
	input  wire logic [PCM_PORTS-1:0][PCM_PINS-1:0] gpio_out_i,
	output logic [PCM_PORTS-1:0][PCM_PINS-1:0]      gpio_in_o,
	input  wire logic [PCM_PORTS-1:0][PCM_PINS-1:0] alt_out_i,
	input  wire logic [PCM_PORTS-1:0][PCM_PINS-1:0] alt_oe_i,
	output logic [PCM_PORTS-1:0][PCM_PINS-1:0]      alt_in_o
);

	logic [15:0] port_c_pin_mode;
	logic [15:0] port_d_pin_mode;
	logic [PCM_PORTS-1:0][15:0] mode_all;
	logic [PCM_PORTS-1:0][PCM_PINS-1:0] sync_a;
	logic [PCM_PORTS-1:0][PCM_PINS-1:0] sync_b;
	logic [PCM_PORTS-1:0][PCM_PINS-1:0] sync_c;
	logic bus_hit;
	logic wr_c;
	logic wr_d;

	assign mode_all[PCM_PORT_C] = port_c_pin_mode;
	assign mode_all[PCM_PORT_D] = port_d_pin_mode;
	assign bus_hit = wb_req_i.cyc & wb_req_i.stb;
	// A write lands on the edge where the master samples ack high.
	assign wr_c = bus_hit & wb_req_i.we & wb_ack_o &
		(wb_req_i.adr == PCM_OFS_C_MODE);
	assign wr_d = bus_hit & wb_req_i.we & wb_ack_o &
		(wb_req_i.adr == PCM_OFS_D_MODE);

	// Turns a mode field into drive, pass-through and pull-up controls.
	function automatic pcm_pin_ctl_type pin_ctl(
		input logic [1:0] mode,
		input logic       out_ok
	);
		pcm_pin_ctl_type ctl;
		ctl = '0;
		case (mode)
			PCM_MODE_ALT: begin
				ctl.pass_alt = 1'b1;
			end
			PCM_MODE_OUT: begin
				ctl.drive_gpio = out_ok;
			end
			PCM_MODE_IN_PU: begin
				ctl.pull_up = 1'b1;
			end
			PCM_MODE_IN: begin
				ctl.pull_up = 1'b0;
			end
			default: begin
				ctl = '0;
			end
		endcase
		return ctl;
	endfunction : pin_ctl

	// The pin with only a dedicated function has no output driver.
	function automatic logic can_drive(input int port, input int pin);
		return !(port == PCM_PORT_D && pin == PCM_DEDICATED);
	endfunction : can_drive

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_hit & ~wb_ack_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_hit & ~wb_ack_o) begin
			case (wb_req_i.adr)
				PCM_OFS_C_MODE: begin
					wb_dat_o <= {16'h0000, port_c_pin_mode};
				end
				PCM_OFS_D_MODE: begin
					wb_dat_o <= {16'h0000, port_d_pin_mode};
				end
				PCM_OFS_LEVEL: begin
					wb_dat_o <= {16'h0000, gpio_in_o[PCM_PORT_D],
						gpio_in_o[PCM_PORT_C]};
				end
				default: begin
					wb_dat_o <= 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_c_pin_mode <= PCM_C_MODE_RESET;
		end else if (wr_c) begin
			if (wb_req_i.sel[0]) begin
				port_c_pin_mode[7:0] <= wb_req_i.dat[7:0];
			end
			if (wb_req_i.sel[1]) begin
				port_c_pin_mode[15:8] <= wb_req_i.dat[15:8];
			end
		end
	end

	// Port D pin 5 stores 01 like any value; only the driver refuses it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_d_pin_mode <= PCM_D_MODE_RESET;
		end else if (wr_d) begin
			if (wb_req_i.sel[0]) begin
				port_d_pin_mode[7:0] <= wb_req_i.dat[7:0];
			end
			if (wb_req_i.sel[1]) begin
				port_d_pin_mode[15:8] <= wb_req_i.dat[15:8];
			end
		end
	end

	// Pads are asynchronous; a level counts once two late stages agree.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_a <= '0;
			sync_b <= '0;
			sync_c <= '0;
		end else begin
			sync_a <= pad_in_i;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gpio_in_o <= '0;
		end else begin
			for (int p = 0; p < PCM_PORTS; p++) begin
				for (int n = 0; n < PCM_PINS; n++) begin
					if (sync_b[p][n] == sync_c[p][n]) begin
						gpio_in_o[p][n] <= sync_c[p][n];
					end
				end
			end
		end
	end

	// Every pad control is registered so a register write cannot glitch
	// pins whose field did not change.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pad_out_o <= '0;
			pad_oe_o  <= '0;
			pull_up_o <= '0;
			alt_in_o  <= '1;
		end else begin
			for (int p = 0; p < PCM_PORTS; p++) begin
				for (int n = 0; n < PCM_PINS; n++) begin
					pcm_pin_ctl_type c;
					c = pin_ctl(mode_all[p][2*n +: PCM_MODE_W],
						can_drive(p, n));
					pull_up_o[p][n] <= c.pull_up;
					if (c.drive_gpio) begin
						pad_out_o[p][n] <= gpio_out_i[p][n];
						pad_oe_o[p][n]  <= 1'b1;
					end else if (c.pass_alt) begin
						pad_out_o[p][n] <= alt_out_i[p][n];
						pad_oe_o[p][n]  <= alt_oe_i[p][n];
					end else begin
						pad_out_o[p][n] <= 1'b0;
						pad_oe_o[p][n]  <= 1'b0;
					end
					// Idle high keeps a deselected peripheral quiet.
					alt_in_o[p][n] <= c.pass_alt ? gpio_in_o[p][n] : 1'b1;
				end
			end
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_reset_c;
		$past(rst_i) |-> port_c_pin_mode == PCM_C_MODE_RESET;
	endproperty
	a_reset_c: assert property (p_reset_c)
		else $error("port C mode register wrong after reset");

	property p_reset_d;
		$past(rst_i) |-> port_d_pin_mode == PCM_D_MODE_RESET;
	endproperty
	a_reset_d: assert property (p_reset_d)
		else $error("port D mode register wrong after reset");

	property p_write_full;
		wr_d && wb_req_i.sel[1:0] == 2'h3
			|=> port_d_pin_mode == $past(wb_req_i.dat[15:0]);
	endproperty
	a_write_full: assert property (p_write_full)
		else $error("full write to port D mode not stored");

	property p_read_back;
		wb_ack_o && !wb_req_i.we && wb_req_i.adr == PCM_OFS_C_MODE
			|-> wb_dat_o == {16'h0000, port_c_pin_mode};
	endproperty
	a_read_back: assert property (p_read_back)
		else $error("port C mode read returned wrong data");

	property p_out_mode;
		port_c_pin_mode[1:0] == PCM_MODE_OUT
			|=> pad_oe_o[0][0] && pad_out_o[0][0] == $past(gpio_out_i[0][0]);
	endproperty
	a_out_mode: assert property (p_out_mode)
		else $error("output mode did not drive port C pin 0");

	property p_alt_mode;
		port_d_pin_mode[1:0] == PCM_MODE_ALT
			|=> pad_oe_o[1][0] == $past(alt_oe_i[1][0]) && !pull_up_o[1][0];
	endproperty
	a_alt_mode: assert property (p_alt_mode)
		else $error("alternate mode did not follow peripheral enable");

	property p_pull_on;
		port_c_pin_mode[15:14] == PCM_MODE_IN_PU
			|=> pull_up_o[0][7] && !pad_oe_o[0][7];
	endproperty
	a_pull_on: assert property (p_pull_on)
		else $error("input with pull-up mode wrong on port C pin 7");

	property p_pull_off;
		port_d_pin_mode[15:14] == PCM_MODE_IN
			|=> !pull_up_o[1][7] && !pad_oe_o[1][7];
	endproperty
	a_pull_off: assert property (p_pull_off)
		else $error("plain input mode wrong on port D pin 7");

	property p_no_drive_pin5;
		port_d_pin_mode[11:10] == PCM_MODE_OUT |=> !pad_oe_o[1][5];
	endproperty
	a_no_drive_pin5: assert property (p_no_drive_pin5)
		else $error("port D pin 5 driven in a refused mode");

	property p_write_to_pin;
		wr_c && wb_req_i.sel[0] && wb_req_i.dat[1:0] == PCM_MODE_OUT
			|-> ##2 pad_oe_o[0][0];
	endproperty
	a_write_to_pin: assert property (p_write_to_pin)
		else $error("port C pin 0 not driven one cycle after write");

	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack stood for more than one cycle");

	property p_ack_answer;
		bus_hit && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer)
		else $error("bus request not answered one cycle later");

	property p_pin5_alt;
		port_d_pin_mode[11:10] == PCM_MODE_ALT
			|=> pad_oe_o[1][5] == $past(alt_oe_i[1][5]);
	endproperty
	a_pin5_alt: assert property (p_pin5_alt)
		else $error("port D pin 5 dedicated function not passed");

	property p_pin5_pull;
		port_d_pin_mode[11:10] == PCM_MODE_IN_PU
			|=> pull_up_o[1][5] && !pad_oe_o[1][5];
	endproperty
	a_pin5_pull: assert property (p_pin5_pull)
		else $error("port D pin 5 input with pull-up mode wrong");

	property p_in_plain;
		port_c_pin_mode[1:0] == PCM_MODE_IN
			|=> !pull_up_o[0][0] && !pad_oe_o[0][0];
	endproperty
	a_in_plain: assert property (p_in_plain)
		else $error("plain input mode wrong on port C pin 0");

	property p_pull_only_mode10;
		port_c_pin_mode[1:0] != PCM_MODE_IN_PU |=> !pull_up_o[0][0];
	endproperty
	a_pull_only_mode10: assert property (p_pull_only_mode10)
		else $error("pull-up on outside input with pull-up mode");

endmodule : pcm_pin_mode
`default_nettype wire

// ===== testbench/pcm_pad_model.sv
// Pad wire model for the pins of ports C and D.
`default_nettype none
module pcm_pad_model (
	input  wire logic [1:0][7:0] pad_out_i,
	input  wire logic [1:0][7:0] pad_oe_i,
	input  wire logic [1:0][7:0] pull_up_i,
	input  wire logic            clk_i,
	output logic      [1:0][7:0] pad_level_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] float_lvl = 16'h0000;
	// A pad left floating has no defined level, so it toggles each cycle.
	always @(posedge clk_i) begin
		float_lvl <= ~float_lvl;
	end
	assign pad_level_o = (pad_oe_i & pad_out_i)
		| (~pad_oe_i & pull_up_i)
		| (~pad_oe_i & ~pull_up_i & float_lvl);
endmodule : pcm_pad_model
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the port C and D pin mode block.
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
 num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
	import pcm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i, rst_i, wb_ack_o;
	logic [31:0] wb_dat_o;
	pcm_wb_req_type req;
	logic [1:0][7:0] pad_in, pad_out, pad_oe, pull_up, gpio_out, gpio_in;
	logic [1:0][7:0] alt_out, alt_oe, alt_in;
	int num_errors = 0;
	int samples_checked = 0;

	pcm_pin_mode u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
		.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .pad_in_i(pad_in),
		.pad_out_o(pad_out), .pad_oe_o(pad_oe), .pull_up_o(pull_up),
		.gpio_out_i(gpio_out), .gpio_in_o(gpio_in), .alt_out_i(alt_out),
		.alt_oe_i(alt_oe), .alt_in_o(alt_in));
	pcm_pad_model u_pads (.pad_out_i(pad_out), .pad_oe_i(pad_oe),
		.pull_up_i(pull_up), .clk_i(clk_i), .pad_level_o(pad_in));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic test_done();
		$display("checked %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	// Returns at the edge where ack is sampled, so callers can time pins.
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [15:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, w, a, 4'h3, {16'h0000, d}};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		req <= '0;
		if (wb_ack_o !== 1'b1) begin
			num_errors++;
			test_done();
		end
	endtask : wb

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		logic [31:0] q;
		wb(1'b0, a, 16'h0000, q);
		`CHK(q, {16'h0000, e})
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
		rd(a, d);
	endtask : wr

	task automatic t_reset();
		rd(PCM_OFS_C_MODE, 16'hF000);
		rd(PCM_OFS_D_MODE, 16'hF0CC);
		rd(8'h0C, 16'h0000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_output();
		logic [31:0] q;
		gpio_out <= {8'hA5, 8'h96};
		wb(1'b1, PCM_OFS_C_MODE, 16'h5555, q);
		#1 `CHK(pad_oe[0], 8'h00)
		@(posedge clk_i);
		#1 `CHK(pad_oe[0], 8'hFF)
		`CHK(pad_out[0], 8'h96)
		repeat (4) @(posedge clk_i);
		#1 `CHK(gpio_in[0], 8'h96)
		$display("test output done");
	endtask : t_output

	task automatic t_inputs();
		wr(PCM_OFS_C_MODE, 16'hAAAA);
		repeat (4) @(posedge clk_i);
		#1 `CHK(pull_up[0], 8'hFF)
		`CHK(pad_oe[0], 8'h00)
		`CHK(gpio_in[0], 8'hFF)
		wr(PCM_OFS_C_MODE, 16'hFFFF);
		#1 `CHK(pull_up[0], 8'h00)
		`CHK(pad_oe[0], 8'h00)
		$display("test inputs done");
	endtask : t_inputs

	task automatic t_alt();
		alt_out <= {8'hC3, 8'h3C};
		alt_oe <= {8'hFF, 8'hFF};
		wr(PCM_OFS_C_MODE, 16'h0000);
		repeat (5) @(posedge clk_i);
		#1 `CHK(pad_oe[0], 8'hFF)
		`CHK(pad_out[0], 8'h3C)
		`CHK(pull_up[0], 8'h00)
		`CHK(alt_in[0], 8'h3C)
		$display("test alternate done");
	endtask : t_alt

	task automatic t_dedicated();
		wr(PCM_OFS_D_MODE, 16'h5555);
		#1 `CHK(pad_oe[1], 8'hDF)
		`CHK(pad_out[1] & 8'hDF, 8'h85)
		`CHK(pull_up[1], 8'h00)
		wr(PCM_OFS_D_MODE, 16'h5955);
		#1 `CHK(pull_up[1], 8'h20)
		`CHK(pad_oe[1], 8'hDF)
		`CHK(alt_in[1], 8'hFF)
		repeat (4) @(posedge clk_i);
		rd(PCM_OFS_LEVEL, 16'hA53C);
		$display("test dedicated done");
	endtask : t_dedicated

	initial begin
		rst_i = 1'b1;
		req = '0;
		gpio_out = 16'h0000;
		alt_out = 16'h0000;
		alt_oe = 16'h0000;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_output();
		t_inputs();
		t_alt();
		t_dedicated();
		test_done();
	end
endmodule : testbench
`default_nettype wire
